// file: design/mdh_regs.svh
// register map, field positions and codes of the microcode download handler
// assumes inclusion by the design file and the bench
`ifndef MDH_REGS_SVH
`define MDH_REGS_SVH
`define MDH_SUBCMD_OFS 8'h00
`define MDH_CNT_LO_OFS 8'h04
`define MDH_CNT_HI_OFS 8'h08
`define MDH_OFS_LO_OFS 8'h0C
`define MDH_OFS_HI_OFS 8'h10
`define MDH_UNIT_OFS 8'h14
`define MDH_OPCODE_OFS 8'h18
`define MDH_FAULT_OFS 8'h1C
`define MDH_COND_OFS 8'h20
`define MDH_DATA_OFS 8'h24
`define MDH_CTRL_OFS 8'h28
`define MDH_IMGLEN_OFS 8'h2C
`define MDH_STATE_OFS 8'h30
`define MDH_OPC_DNLD 8'h92
`define MDH_SUB_OFS 8'h03
`define MDH_SUB_FULL 8'h07
`define MDH_SUB_DEFER 8'h0E
`define MDH_SUB_ACT 8'h0F
`define MDH_FLT_UNC 6
`define MDH_FLT_ABT 2
`define MDH_CTRL_LOCK 0
`define MDH_CTRL_SPINDIS 1
`define MDH_BLOCK_BYTES 512
`define MDH_COND_RST 8'h50
`define MDH_IMGLEN_RST 16'h0001
`define MDH_RESP_OKAY 2'h0
`define MDH_RESP_DECERR 2'h3
`endif

// file: design/mdh_pkg.sv
// types shared by the microcode download handler and its bench
// assumes nothing beyond a SystemVerilog compiler
package mdh_pkg;
    typedef enum logic [2:0] {
        MDH_IDLE = 3'b001,
        MDH_DATA = 3'b010,
        MDH_RELOAD = 3'b100
    } mdh_state_t;

    // one word toward the image store
    typedef struct packed {
        logic we;
        logic [22:0] addr;
        logic [31:0] data;
    } mdh_img_wr_t;

    // one-cycle pulses toward the firmware engine
    typedef struct packed {
        logic store;
        logic activate;
        logic discard;
        logic spin_down;
    } mdh_fw_evt_t;
endpackage : mdh_pkg

// file: design/mdh_download.sv
// microcode download command handler behind an AXI4-Lite register slave
// assumes a firmware engine on clk that verifies, stores and reloads images
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mdh_regs.svh"

module mdh_download #(
    parameter int IMG_AW = 23
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // firmware engine
    input wire logic verify_ok,
    input wire logic reload_done,
    input wire logic reload_ok,
    output mdh_pkg::mdh_img_wr_t img_wr,
    output mdh_pkg::mdh_fw_evt_t fw_evt
);
    localparam int WPB = `MDH_BLOCK_BYTES / 4;

    // image address field is fixed at 16-bit block plus 7-bit word
    if (IMG_AW != 23 || WPB != 128) begin : g_chk
        $error("IMG_AW must be 23 and a block must be 128 words");
    end

    mdh_pkg::mdh_state_t state_reg;
    logic [7:0] awaddr_reg, sub_reg, cnt_lo_reg, cnt_hi_reg;
    logic [7:0] ofs_lo_reg, ofs_hi_reg, unit_reg, fault_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_hold_reg, w_hold_reg, err_reg, lock_reg, spindis_reg;
    logic [15:0] img_len_reg, expect_reg, seg_ofs_reg, seg_cnt_reg;
    logic [7:0] mode_reg;
    logic [22:0] words_left_reg;
    logic pending_reg, partial_reg, rld_req_reg, first_word_reg;

    // write decode
    wire wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    wire b0 = wstrb_reg[0];
    wire wr_sub = wr_fire && b0 && awaddr_reg == `MDH_SUBCMD_OFS;
    wire wr_clo = wr_fire && b0 && awaddr_reg == `MDH_CNT_LO_OFS;
    wire wr_chi = wr_fire && b0 && awaddr_reg == `MDH_CNT_HI_OFS;
    wire wr_olo = wr_fire && b0 && awaddr_reg == `MDH_OFS_LO_OFS;
    wire wr_ohi = wr_fire && b0 && awaddr_reg == `MDH_OFS_HI_OFS;
    wire wr_unit = wr_fire && b0 && awaddr_reg == `MDH_UNIT_OFS;
    wire wr_opc = wr_fire && b0 && awaddr_reg == `MDH_OPCODE_OFS;
    wire wr_ctrl = wr_fire && b0 && awaddr_reg == `MDH_CTRL_OFS;
    wire wr_len = wr_fire && awaddr_reg == `MDH_IMGLEN_OFS;
    wire wr_data = wr_fire && awaddr_reg == `MDH_DATA_OFS;
    wire wr_map = awaddr_reg[1:0] == 2'h0 && awaddr_reg <= `MDH_STATE_OFS;
    wire rd_map = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= `MDH_STATE_OFS;

    // command decode
    wire idle = state_reg == mdh_pkg::MDH_IDLE;
    wire cmd_go = wr_opc && wdata_reg[7:0] == `MDH_OPC_DNLD && idle;
    wire [15:0] cnt_w = {cnt_hi_reg, cnt_lo_reg};
    wire [15:0] ofs_w = {ofs_hi_reg, ofs_lo_reg};
    wire sub_ofs = sub_reg == `MDH_SUB_OFS || sub_reg == `MDH_SUB_DEFER;
    wire sub_ok = sub_ofs || sub_reg == `MDH_SUB_FULL
        || sub_reg == `MDH_SUB_ACT;
    wire cmd_abt = !sub_ok || lock_reg;
    wire is_act = sub_reg == `MDH_SUB_ACT;
    wire ofs_bad = sub_ofs && ofs_w != expect_reg;
    wire cnt_zero = cnt_w == 16'h0000;
    // offset ignored by 07h, which always starts at block zero
    wire [15:0] start_blk = sub_ofs ? ofs_w : 16'h0000;
    wire to_data = cmd_go && !cmd_abt && !is_act && !ofs_bad && !cnt_zero;

    // segment progress
    wire in_data = state_reg == mdh_pkg::MDH_DATA;
    wire data_fire = wr_data && in_data;
    wire seg_done = data_fire && words_left_reg == 23'h000001;
    wire [16:0] seg_end = {1'b0, seg_ofs_reg} + {1'b0, seg_cnt_reg};
    wire last_seg = mode_reg == `MDH_SUB_FULL
        || seg_end >= {1'b0, img_len_reg};
    wire in_rld = state_reg == mdh_pkg::MDH_RELOAD;
    wire rld_end = in_rld && reload_done;

    // status: bsy rdy df dsc drq cor idx err
    wire [7:0] cond_w = {in_rld, 1'b1, 1'b0, 1'b1, in_data,
        2'b00, err_reg};
    wire [7:0] ctrl_w = {6'h00, spindis_reg, lock_reg};
    wire [31:0] state_w = {expect_reg, 5'h00, state_reg,
        5'h00, rld_req_reg, partial_reg, pending_reg};

    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            `MDH_CNT_LO_OFS: rd_mux = {24'h000000, cnt_lo_reg};
            `MDH_CNT_HI_OFS: rd_mux = {24'h000000, cnt_hi_reg};
            `MDH_OFS_LO_OFS: rd_mux = {24'h000000, ofs_lo_reg};
            `MDH_OFS_HI_OFS: rd_mux = {24'h000000, ofs_hi_reg};
            `MDH_UNIT_OFS: rd_mux = {24'h000000, unit_reg};
            `MDH_FAULT_OFS: rd_mux = {24'h000000, fault_reg};
            `MDH_COND_OFS: rd_mux = {24'h000000, cond_w};
            `MDH_CTRL_OFS: rd_mux = {24'h000000, ctrl_w};
            `MDH_IMGLEN_OFS: rd_mux = {16'h0000, img_len_reg};
            `MDH_STATE_OFS: rd_mux = state_w;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // axi write channels, taken in either order
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MDH_RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg <= s_axi_awaddr;
                aw_hold_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                w_hold_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `MDH_RESP_OKAY : `MDH_RESP_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // axi read channel, answer one cycle after the address
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MDH_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_map ? `MDH_RESP_OKAY : `MDH_RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // command block registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sub_reg <= 8'h00;
            cnt_lo_reg <= 8'h00;
            cnt_hi_reg <= 8'h00;
            ofs_lo_reg <= 8'h00;
            ofs_hi_reg <= 8'h00;
            unit_reg <= 8'h00;
            lock_reg <= 1'b0;
            spindis_reg <= 1'b0;
            img_len_reg <= `MDH_IMGLEN_RST;
        end else begin
            if (wr_sub) sub_reg <= wdata_reg[7:0];
            if (wr_clo) cnt_lo_reg <= wdata_reg[7:0];
            if (wr_chi) cnt_hi_reg <= wdata_reg[7:0];
            if (wr_olo) ofs_lo_reg <= wdata_reg[7:0];
            if (wr_ohi) ofs_hi_reg <= wdata_reg[7:0];
            if (wr_unit) unit_reg <= wdata_reg[7:0];
            if (wr_ctrl) begin
                lock_reg <= wdata_reg[`MDH_CTRL_LOCK];
                spindis_reg <= wdata_reg[`MDH_CTRL_SPINDIS];
            end
            if (wr_len && wstrb_reg[0]) img_len_reg[7:0] <= wdata_reg[7:0];
            if (wr_len && wstrb_reg[1]) img_len_reg[15:8] <= wdata_reg[15:8];
        end
    end

    // command sequencer; image state lives only in flops, so the
    // asynchronous power-on reset drops every partial or stored image
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= mdh_pkg::MDH_IDLE;
            fault_reg <= 8'h00;
            err_reg <= 1'b0;
            expect_reg <= 16'h0000;
            seg_ofs_reg <= 16'h0000;
            seg_cnt_reg <= 16'h0000;
            mode_reg <= 8'h00;
            words_left_reg <= 23'h000000;
            pending_reg <= 1'b0;
            partial_reg <= 1'b0;
            rld_req_reg <= 1'b0;
            first_word_reg <= 1'b0;
            img_wr <= '0;
            fw_evt <= '0;
        end else begin
            img_wr.we <= 1'b0;
            fw_evt <= '0;
            case (state_reg)
                mdh_pkg::MDH_IDLE: begin
                    if (cmd_go) begin
                        fault_reg <= 8'h00;
                        err_reg <= 1'b0;
                        if (cmd_abt) begin
                            fault_reg[`MDH_FLT_ABT] <= 1'b1;
                            err_reg <= 1'b1;
                        end else if (is_act) begin
                            if (pending_reg) begin
                                pending_reg <= 1'b0;
                                rld_req_reg <= 1'b1;
                                fw_evt.activate <= 1'b1;
                                state_reg <= mdh_pkg::MDH_RELOAD;
                            end else begin
                                fault_reg[`MDH_FLT_ABT] <= 1'b1;
                                err_reg <= 1'b1;
                            end
                        end else if (ofs_bad) begin
                            fault_reg[`MDH_FLT_ABT] <= 1'b1;
                            err_reg <= 1'b1;
                            fw_evt.discard <= partial_reg;
                            partial_reg <= 1'b0;
                            expect_reg <= 16'h0000;
                        end else if (!cnt_zero) begin
                            state_reg <= mdh_pkg::MDH_DATA;
                            mode_reg <= sub_reg;
                            seg_ofs_reg <= start_blk;
                            seg_cnt_reg <= cnt_w;
                            words_left_reg <= {cnt_w, 7'h00};
                            img_wr.addr <= IMG_AW'({start_blk, 7'h00});
                            first_word_reg <= start_blk == 16'h0000;
                            partial_reg <= 1'b1;
                        end
                    end
                end
                mdh_pkg::MDH_DATA: begin
                    if (data_fire) begin
                        img_wr.we <= 1'b1;
                        img_wr.data <= wdata_reg;
                        // words come several cycles apart; step from 2nd on
                        if (words_left_reg != {seg_cnt_reg, 7'h00})
                            img_wr.addr <= img_wr.addr + 23'h000001;
                        if (first_word_reg)
                            rld_req_reg <= wdata_reg[0];
                        first_word_reg <= 1'b0;
                        words_left_reg <= words_left_reg - 23'h000001;
                    end
                    if (seg_done) begin
                        expect_reg <= seg_end[15:0];
                        state_reg <= mdh_pkg::MDH_IDLE;
                        if (last_seg) begin
                            partial_reg <= 1'b0;
                            expect_reg <= 16'h0000;
                            if (!verify_ok) begin
                                fault_reg[`MDH_FLT_ABT] <= 1'b1;
                                err_reg <= 1'b1;
                                fw_evt.discard <= 1'b1;
                            end else begin
                                fw_evt.store <= 1'b1;
                                if (mode_reg == `MDH_SUB_DEFER) begin
                                    pending_reg <= 1'b1;
                                end else begin
                                    pending_reg <= 1'b0;
                                    fw_evt.activate <= 1'b1;
                                    state_reg <= mdh_pkg::MDH_RELOAD;
                                end
                            end
                        end
                    end
                end
                mdh_pkg::MDH_RELOAD: begin
                    if (reload_done) begin
                        if (rld_req_reg && !reload_ok) begin
                            fault_reg[`MDH_FLT_UNC] <= 1'b1;
                            err_reg <= 1'b1;
                        end
                        fw_evt.spin_down <= spindis_reg;
                        rld_req_reg <= 1'b0;
                        state_reg <= mdh_pkg::MDH_IDLE;
                    end
                end
                default: state_reg <= mdh_pkg::MDH_IDLE;
            endcase
        end
    end

    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_reload_end;
        in_rld && reload_done;
    endsequence

    sequence s_status_idle;
        idle && cond_w[7:1] == 7'h28;
    endsequence

    a_zero_count: assert property (cmd_go && !cmd_abt
        && !is_act && !ofs_bad && cnt_zero |=> !in_data && idle && !err_reg)
        else $error("zero count command raised a data request");
    a_bad_sub: assert property (cmd_go && (!sub_ok || lock_reg)
        |=> fault_reg[`MDH_FLT_ABT] && err_reg && idle)
        else $error("reserved subcommand or lock not aborted");
    a_offset_gap: assert property (cmd_go && !cmd_abt
        && ofs_bad |=> fault_reg[`MDH_FLT_ABT] && expect_reg == 16'h0000
        && !partial_reg)
        else $error("offset gap did not abort and restart");
    a_word_count: assert property (to_data
        |=> in_data && words_left_reg == {cnt_hi_reg, cnt_lo_reg, 7'h00})
        else $error("segment length not count times 128 words");
    a_defer_hold: assert property (seg_done && last_seg
        && verify_ok && mode_reg == `MDH_SUB_DEFER
        |=> pending_reg && !fw_evt.activate && idle)
        else $error("deferred image was activated");
    a_activate_cmd: assert property (cmd_go && !cmd_abt
        && is_act && pending_reg
        |=> fw_evt.activate && !pending_reg && in_rld)
        else $error("activate subcommand did not start reload");
    a_unc_request: assert property (s_reload_end
        ##0 !rld_req_reg |=> !fault_reg[`MDH_FLT_UNC])
        else $error("uncorrectable raised without a reload request");
    a_spin_down: assert property (s_reload_end
        ##0 spindis_reg |=> fw_evt.spin_down ##1 !fw_evt.spin_down)
        else $error("no single spin down pulse after reload");
    a_done_status: assert property (s_reload_end
        |=> s_status_idle)
        else $error("completion status not ready and seek done");
    a_immediate: assert property (seg_done && last_seg
        && verify_ok && mode_reg != `MDH_SUB_DEFER
        |=> fw_evt.store && fw_evt.activate ##1 in_rld)
        else $error("final segment did not save and activate");
    a_write_resp: assert property (wr_fire |=> s_axi_bvalid
        && !aw_hold_reg && !w_hold_reg)
        else $error("write not answered one cycle after both halves");
endmodule : mdh_download

// file: tb/mdh_fw_model.sv
// firmware engine stand-in: verify verdict and delayed reload pulse
// assumes the handler's event pulses and the bench controls share clk
`timescale 1ns/1ps
module mdh_fw_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // handler side
    input wire mdh_pkg::mdh_fw_evt_t fw_evt,
    output logic verify_ok,
    output logic reload_done,
    output logic reload_ok,
    // bench controls
    input wire logic vfy_cfg,
    input wire logic rld_cfg,
    input wire logic [3:0] dly
);
    logic [4:0] cnt_reg;
    assign verify_ok = vfy_cfg;
    // verdict only valid beside the pulse, shown inverted elsewhere
    assign reload_ok = reload_done ? rld_cfg : ~rld_cfg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 5'h00;
            reload_done <= 1'b0;
        end else begin
            reload_done <= (cnt_reg == 5'h01);
            if (fw_evt.activate) cnt_reg <= {1'b0, dly} + 5'h01;
            else if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
        end
    end
endmodule : mdh_fw_model

// file: tb/tb_microcode_download_handler.sv
// self-checking bench of the download handler, axi4-lite master side
// assumes the firmware engine model beside the handler
`timescale 1ns/1ps
`include "mdh_regs.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_microcode_download_handler;
    logic clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, vfy = 1, rld = 1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, last_d;
    logic [3:0] wstrb = 4'hF, dly = 4'h1;
    logic [1:0] bresp, rresp, last_b;
    logic awready, wready, bvalid, arready, rvalid, vok, rdone, rok;
    logic [22:0] exp_addr;
    mdh_pkg::mdh_img_wr_t img_wr;
    mdh_pkg::mdh_fw_evt_t fw_evt;
    int seed = 37, mismatches = 0, n_checks = 0;
    int n_we, n_store, n_act, n_disc, n_spin;
    always #20 clk = ~clk;
    mdh_download DUT (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .verify_ok(vok), .reload_done(rdone),
        .reload_ok(rok), .img_wr(img_wr), .fw_evt(fw_evt));
    mdh_fw_model FW (.clk(clk), .nrst(nrst), .fw_evt(fw_evt),
        .verify_ok(vok), .reload_done(rdone), .reload_ok(rok),
        .vfy_cfg(vfy), .rld_cfg(rld), .dly(dly));
    // negedge view avoids racing the design's flops
    always @(negedge clk) begin
        if (img_wr.we === 1'b1) begin
            `CHK(img_wr.addr, exp_addr)
            `CHK(img_wr.data, last_d)
            exp_addr++;
            n_we++;
        end
        n_store += (fw_evt.store === 1'b1);
        n_act += (fw_evt.activate === 1'b1);
        n_disc += (fw_evt.discard === 1'b1);
        n_spin += (fw_evt.spin_down === 1'b1);
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic hang();
        mismatches++;
        end_sim();
    endtask : hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        logic aw_hs, w_hs, b_hs;
        // one edge between calls, so bready never toggles in one step
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            last_b = bresp;
            @(posedge clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) begin
                bready <= 1'b0;
                break;
            end
        end
        if (i == 40) hang();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        int i;
        logic ar_hs, r_hs;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) begin
                rready <= 1'b0;
                break;
            end
        end
        if (i == 40) hang();
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK(d, e)
    endtask : rchk
    function automatic logic [31:0] fexp(input bit abt, input bit unc);
        return {24'h0, 1'b0, unc, 3'h0, abt, 2'h0};
    endfunction : fexp
    function automatic int nwords(input int blocks);
        return blocks * `MDH_BLOCK_BYTES / 4;
    endfunction : nwords
    task automatic clr();
        {n_we, n_store, n_act, n_disc, n_spin} = '0;
    endtask : clr
    task automatic cmd(input logic [7:0] sub, input logic [15:0] cnt,
            input logic [15:0] ofs, input logic rq, input int nw,
            input bit wt);
        int i;
        logic [31:0] d;
        logic [1:0] r;
        exp_addr = (sub == `MDH_SUB_FULL) ? 23'h0 : {ofs, 7'h00};
        wr(`MDH_SUBCMD_OFS, {24'h0, sub});
        wr(`MDH_CNT_LO_OFS, {24'h0, cnt[7:0]});
        wr(`MDH_CNT_HI_OFS, {24'h0, cnt[15:8]});
        wr(`MDH_OFS_LO_OFS, {24'h0, ofs[7:0]});
        wr(`MDH_OFS_HI_OFS, {24'h0, ofs[15:8]});
        wr(`MDH_OPCODE_OFS, {24'h0, `MDH_OPC_DNLD});
        if (nw > 0) rchk(`MDH_COND_OFS, 32'h58);
        for (i = 0; i < nw; i++) begin
            d = $random(seed);
            if (i == 0) d[0] = rq;
            last_d = d;
            wr(`MDH_DATA_OFS, d);
        end
        for (i = 0; i < 60 && wt; i++) begin
            rd(`MDH_COND_OFS, d, r);
            if (d[7] === 1'b0) break;
        end
        if (i == 60) hang();
    endtask : cmd
    initial begin
        int k;
        logic [7:0] s;
        logic [31:0] d;
        logic [1:0] r;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rchk(`MDH_COND_OFS, 32'h50);
        rchk(`MDH_IMGLEN_OFS, 32'h1);
        rd(8'h34, d, r);
        `CHK(r, `MDH_RESP_DECERR)
        wr(8'h31, 32'h1);
        `CHK(last_b, `MDH_RESP_DECERR)
        for (k = 0; k < 6; k++) begin
            s = 8'($random(seed));
            if (s inside {8'h03, 8'h07, 8'h0E, 8'h0F}) s = 8'h01;
            cmd(s, 16'h1, 16'h0, 1'b0, 0, 1'b1);
            rchk(`MDH_FAULT_OFS, fexp(1, 0));
            rchk(`MDH_COND_OFS, 32'h51);
        end
        wr(`MDH_CTRL_OFS, 32'h1);
        cmd(`MDH_SUB_FULL, 16'h1, 16'h0, 1'b0, 0, 1'b1);
        rchk(`MDH_FAULT_OFS, fexp(1, 0));
        wr(`MDH_CTRL_OFS, 32'h2);
        clr();
        cmd(`MDH_SUB_FULL, 16'h0, 16'h0, 1'b0, 0, 1'b1);
        `CHK(n_we, 0)
        rchk(`MDH_COND_OFS, 32'h50);
        rld <= 1'b0;
        dly <= 4'($random(seed));
        cmd(`MDH_SUB_FULL, 16'h1, 16'h1234, 1'b1, nwords(1), 1'b1);
        `CHK({n_we, n_store}, {nwords(1), 32'd1})
        `CHK({n_act, n_spin}, {32'd1, 32'd1})
        rchk(`MDH_FAULT_OFS, fexp(0, 1));
        rchk(`MDH_COND_OFS, 32'h51);
        wr(`MDH_CTRL_OFS, 32'h0);
        clr();
        cmd(`MDH_SUB_FULL, 16'h1, 16'h0, 1'b0, nwords(1), 1'b1);
        `CHK({n_act, n_spin}, {32'd1, 32'd0})
        rchk(`MDH_FAULT_OFS, fexp(0, 0));
        wr(`MDH_OPCODE_OFS, 32'h93);
        rchk(`MDH_COND_OFS, 32'h50);
        rld <= 1'b1;
        wr(`MDH_IMGLEN_OFS, 32'h2);
        clr();
        cmd(`MDH_SUB_DEFER, 16'h1, 16'h0, 1'b1, nwords(1), 1'b1);
        `CHK(n_store, 0)
        cmd(`MDH_SUB_DEFER, 16'h1, 16'h1, 1'b0, nwords(1), 1'b1);
        `CHK({n_store, n_act}, {32'd1, 32'd0})
        cmd(`MDH_SUB_ACT, 16'h0, 16'h0, 1'b0, 0, 1'b1);
        `CHK(n_act, 1)
        cmd(`MDH_SUB_ACT, 16'h0, 16'h0, 1'b0, 0, 1'b1);
        rchk(`MDH_FAULT_OFS, fexp(1, 0));
        clr();
        cmd(`MDH_SUB_OFS, 16'h1, 16'h0, 1'b0, nwords(1), 1'b1);
        cmd(`MDH_SUB_OFS, 16'h1, 16'h3, 1'b0, 0, 1'b1);
        rchk(`MDH_FAULT_OFS, fexp(1, 0));
        `CHK(n_disc, 1)
        cmd(`MDH_SUB_OFS, 16'h1, 16'h1, 1'b0, 0, 1'b1);
        rchk(`MDH_FAULT_OFS, fexp(1, 0));
        cmd(`MDH_SUB_OFS, 16'h2, 16'h0, 1'b1, nwords(2), 1'b1);
        `CHK({n_store, n_act}, {32'd1, 32'd1})
        rchk(`MDH_FAULT_OFS, fexp(0, 0));
        vfy <= 1'b0;
        clr();
        cmd(`MDH_SUB_FULL, 16'h2, 16'h0, 1'b0, nwords(2), 1'b1);
        `CHK({n_disc, n_act}, {32'd1, 32'd0})
        vfy <= 1'b1;
        cmd(`MDH_SUB_DEFER, 16'h100, 16'h0, 1'b0, 2, 1'b0);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rchk(`MDH_STATE_OFS, 32'h100);
        cmd(`MDH_SUB_DEFER, 16'h1, 16'h0, 1'b0, nwords(1), 1'b1);
        rchk(`MDH_STATE_OFS, 32'h101);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        cmd(`MDH_SUB_ACT, 16'h0, 16'h0, 1'b0, 0, 1'b1);
        rchk(`MDH_FAULT_OFS, fexp(1, 0));
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge clk);
        hang();
    end
endmodule : tb_microcode_download_handler
